// ### dv/prc_top_assertions.sv
`timescale 1ns/100ps
// ==========================================================
// port checks of the reset bank
module prc_top_chk
(
   input wire        mclk,
   input wire        sys_rst,
   input wire [7:0]  reg_addr,
   input wire [31:0] reg_wdata,
   input wire [3:0]  reg_be,
   input wire        reg_wr,
   input wire        reg_rd,
   input wire [31:0] reg_rdata_ff,
   input wire        port_a_reset,
   input wire        timer_ten_reset,
   input wire        alt_function_io_reset,
   input wire        dac_unit_reset,
   input wire        first_i2c_reset
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   sequence s_fwr; reg_wr && reg_addr[7:2] == 6'h03; endsequence
   sequence s_swr; reg_wr && reg_addr[7:2] == 6'h04; endsequence
   a_port_a_wr: assert property (s_fwr ##0 reg_be[0] |=> port_a_reset == $past(reg_wdata[2]))
      else $error("port a reset wrong");
   a_port_a_hold: assert property (!sys_rst && !(reg_wr && reg_addr[7:2] == 6'h03) |=>
      $stable(port_a_reset)) else $error("port a reset moved");
   a_timer_ten_wr: assert property (s_fwr ##0 reg_be[2] |=> timer_ten_reset == $past(reg_wdata[21]))
      else $error("timer ten reset wrong");
   a_alt_func_wr: assert property (s_fwr ##0 reg_be[0] |=> alt_function_io_reset == $past(reg_wdata[0]))
      else $error("alt function reset wrong");
   a_dac_wr: assert property (s_swr ##0 reg_be[3] |=> dac_unit_reset == $past(reg_wdata[29]))
      else $error("dac reset wrong");
   a_i2c_wr: assert property (s_swr ##0 reg_be[2] |=> first_i2c_reset == $past(reg_wdata[21]))
      else $error("i2c reset wrong");
   a_fast_read: assert property (reg_rd && reg_addr[7:2] == 6'h03 |=>
      reg_rdata_ff[2] == port_a_reset && reg_rdata_ff[31:22] == 10'h0) else $error("fast read wrong");
   a_reset_clear: assert property (disable iff (1'b0) sys_rst |=>
      !port_a_reset && !dac_unit_reset && reg_rdata_ff == 32'h0) else $error("reset not clear");
endmodule
bind prc_top prc_top_chk i_chk (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_be(reg_be), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .port_a_reset(port_a_reset),
   .timer_ten_reset(timer_ten_reset), .alt_function_io_reset(alt_function_io_reset),
   .dac_unit_reset(dac_unit_reset), .first_i2c_reset(first_i2c_reset));

// ### dv/prc_top_bench.sv
`timescale 1ns/100ps
// ==========================================================
// register-level bench
module prc_top_bench;
   reg         mclk = 1'b0;
   reg         sys_rst = 1'b1;
   reg  [7:0]  reg_addr = 8'h00;
   reg  [31:0] reg_wdata = 32'h0;
   reg  [3:0]  reg_be = 4'h0;
   reg         reg_wr = 1'b0;
   reg         reg_rd = 1'b0;
   wire [31:0] reg_rdata_ff;
   wire [14:0] fo;
   wire [6:0]  so;
   integer     bad_count = 0;
   integer     check_count = 0;
   integer     i;
   reg  [31:0] fr;
   reg  [31:0] sr;
   reg  [7:0]  a;
   reg  [21:0] eo;
   wire [21:0] outs;
   assign outs = {fo, so};
`define CHK(nm, e, g) begin check_count = check_count + 1; if ((g) !== (e)) begin \
   bad_count = bad_count + 1; $display("[ERR] %s exp %h got %h", nm, e, g); end end
   prc_top i_dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_be(reg_be),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .timer_ten_reset(fo[14]),
      .timer_nine_reset(fo[13]), .timer_eight_reset(fo[12]), .first_usart_reset(fo[11]),
      .second_advanced_timer_reset(fo[10]), .first_spi_reset(fo[9]), .first_advanced_timer_reset(fo[8]),
      .second_adc_reset(fo[7]), .first_adc_reset(fo[6]), .port_e_reset(fo[5]), .port_d_reset(fo[4]),
      .port_c_reset(fo[3]), .port_b_reset(fo[2]), .port_a_reset(fo[1]), .alt_function_io_reset(fo[0]),
      .dac_unit_reset(so[6]), .power_control_reset(so[5]), .backup_interface_reset(so[4]),
      .second_can_reset(so[3]), .first_can_reset(so[2]), .second_i2c_reset(so[1]), .first_i2c_reset(so[0]));
   initial
   begin
      forever #2 mclk = ~mclk;
   end
   // model applies lanes and drops reserved bits, then outputs are checked the cycle after
   task wr(input [7:0] ad, input [31:0] d, input [3:0] b);
      reg [31:0] lm;
      begin
         lm = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
         @(posedge mclk);
         reg_wr <= 1'b1;
         reg_addr <= ad;
         reg_wdata <= d;
         reg_be <= b;
         @(posedge mclk);
         reg_wr <= 1'b0;
         if (ad == 8'h0c) fr = (fr & ~lm) | (d & lm & 32'h0038_7e7d);
         if (ad == 8'h10) sr = (sr & ~lm) | (d & lm & 32'h3e60_0000);
         #1;
         eo = {fr[21:19], fr[14:9], fr[6:2], fr[0], sr[29:25], sr[22:21]};
         `CHK("outs", eo, outs)
      end
   endtask
   task rd(input [7:0] ad, input [31:0] e);
      begin
         @(posedge mclk);
         reg_rd <= 1'b1;
         reg_addr <= ad;
         @(posedge mclk);
         reg_rd <= 1'b0;
         #1;
         `CHK("rdata", e, reg_rdata_ff)
         @(posedge mclk);
         #1;
         `CHK("rdata idle", 32'h0000_0000, reg_rdata_ff)
      end
   endtask
   task end_of_test;
      begin
         $display("checks %0d mismatches %0d", check_count, bad_count);
         if (bad_count == 0 && check_count > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   initial
   begin
      fr = 32'h0;
      sr = 32'h0;
      repeat (3) @(posedge mclk);
      sys_rst <= 1'b0;
      #1;
      `CHK("outs after reset", 22'h00_0000, outs)
      rd(8'h0c, 32'h0);
      rd(8'h10, 32'h0);
      $display("reset values done");
      for (i = 0; i < 64; i = i + 1)
      begin
         a = (i < 32) ? 8'h0c : 8'h10;
         wr(a, 32'h1 << (i % 32), 4'hf);
         rd(a, (i < 32) ? fr : sr);
      end
      $display("bit walk done");
      wr(8'h0c, 32'hffff_ffff, 4'hf);
      wr(8'h0c, 32'h0, 4'h1);
      wr(8'h0c, 32'h0, 4'hc);
      rd(8'h0c, fr);
      wr(8'h10, 32'hffff_ffff, 4'h8);
      wr(8'h14, 32'hffff_ffff, 4'hf);
      rd(8'h14, 32'h0);
      rd(8'h10, sr);
      $display("lanes and unmapped done");
      @(posedge mclk);
      sys_rst <= 1'b1;
      @(posedge mclk);
      sys_rst <= 1'b0;
      fr = 32'h0;
      sr = 32'h0;
      #1;
      `CHK("outs after reset", 22'h00_0000, outs)
      rd(8'h0c, 32'h0);
      rd(8'h10, 32'h0);
      $display("second reset done");
      end_of_test;
   end
endmodule

// ### verilog/prc_bank.v
`timescale 1ns/100ps

// ==========================================================
// one software-owned reset register with byte-lane writes
module prc_bank
#(
   parameter          WIDTH   = 32,
   parameter [31:0]   RST_VAL = 32'h0000_0000,
   parameter [31:0]   WMASK   = 32'hffff_ffff
)
(
   input  wire              mclk,
   input  wire              sys_rst,
   input  wire              wr_en,
   input  wire [3:0]        wr_be,
   input  wire [WIDTH-1:0]  wr_data,
   output reg  [WIDTH-1:0]  q_ff
);

   wire [WIDTH-1:0] nxt_q;

   genvar b;
   generate
      for (b = 0; b < WIDTH; b = b + 1)
      begin : g_bit
         // reserved bits never store, so they always hold their RST_VAL bit from reset
         assign nxt_q[b] = (WMASK[b] & wr_en & wr_be[b/8]) ? wr_data[b] : q_ff[b];
      end
   endgenerate

   always @(posedge mclk)
   begin
      if (sys_rst)
         q_ff <= RST_VAL[WIDTH-1:0];
      else
         q_ff <= nxt_q;
   end

endmodule

// ### verilog/prc_regs.vh
`ifndef PRC_REGS_VH
`define PRC_REGS_VH

// ==========================================================
// register map (byte offsets, word aligned)
`define PRC_ADDR_W          8
`define PRC_FAST_RST_OFS    8'h0c
`define PRC_SLOW_RST_OFS    8'h10

// ==========================================================
// reset values
`define PRC_FAST_RST_RST    32'h0000_0000
`define PRC_SLOW_RST_RST    32'h0000_0000

// ==========================================================
// writable bits; everything else is reserved and reads zero
`define PRC_FAST_RST_WMASK  32'h0038_7e7d
`define PRC_SLOW_RST_WMASK  32'h3e60_0000

// ==========================================================
// fast bus reset register fields
`define PRC_F_TIMER_TEN     21
`define PRC_F_TIMER_NINE    20
`define PRC_F_TIMER_EIGHT   19
`define PRC_F_USART0        14
`define PRC_F_ADV_TIMER1    13
`define PRC_F_SPI0          12
`define PRC_F_ADV_TIMER0    11
`define PRC_F_ADC1          10
`define PRC_F_ADC0          9
`define PRC_F_PORT_E        6
`define PRC_F_PORT_D        5
`define PRC_F_PORT_C        4
`define PRC_F_PORT_B        3
`define PRC_F_PORT_A        2
`define PRC_F_ALT_FUNC      0

// ==========================================================
// slow bus reset register fields
`define PRC_S_DAC           29
`define PRC_S_POWER         28
`define PRC_S_BACKUP        27
`define PRC_S_CAN1          26
`define PRC_S_CAN0          25
`define PRC_S_I2C1          22
`define PRC_S_I2C0          21

`endif

// ### verilog/prc_top.v
// Behaviour
// - Byte, half-word and word writes are accepted and only the enabled byte lanes change.
// - The first reset register sits at offset 0x0c and clears to zero on system reset.
// - Reset bits change only by software writes and system reset; one holds the peripheral in reset, zero releases it.
// - First register bits 21, 20 and 19 reset the tenth, ninth and eighth general timers.
// - First register bits 6 down to 2 reset GPIO ports E, D, C, B and A, each on its own.
// - First register bit 0 resets the alternate-function I/O remap logic.
// - Reserved bits read zero and software writes them only with zero.
// - The second reset register sits at offset 0x10 and clears to zero on system reset.
// - Second register bit 29 resets the DAC, bit 28 the power control; 31:30 and 24:23 are reserved.
// - Second register bit 27 resets the backup interface, 26 and 25 the CANs, 22 and 21 the I2Cs.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
`include "prc_regs.vh"

module prc_top
(
   input  wire                     mclk,
   input  wire                     sys_rst,
   input  wire [`PRC_ADDR_W-1:0]   reg_addr,
   input  wire [31:0]              reg_wdata,
   input  wire [3:0]               reg_be,
   input  wire                     reg_wr,
   input  wire                     reg_rd,
   output reg  [31:0]              reg_rdata_ff,
   output wire                     timer_ten_reset,
   output wire                     timer_nine_reset,
   output wire                     timer_eight_reset,
   output wire                     first_usart_reset,
   output wire                     second_advanced_timer_reset,
   output wire                     first_spi_reset,
   output wire                     first_advanced_timer_reset,
   output wire                     second_adc_reset,
   output wire                     first_adc_reset,
   output wire                     port_e_reset,
   output wire                     port_d_reset,
   output wire                     port_c_reset,
   output wire                     port_b_reset,
   output wire                     port_a_reset,
   output wire                     alt_function_io_reset,
   output wire                     dac_unit_reset,
   output wire                     power_control_reset,
   output wire                     backup_interface_reset,
   output wire                     second_can_reset,
   output wire                     first_can_reset,
   output wire                     second_i2c_reset,
   output wire                     first_i2c_reset
);

   // ==========================================================
   // address decode
   localparam [`PRC_ADDR_W-1:0] FAST_OFS = `PRC_FAST_RST_OFS;
   localparam [`PRC_ADDR_W-1:0] SLOW_OFS = `PRC_SLOW_RST_OFS;

   wire        sel_fast;
   wire        sel_slow;
   wire        wr_fast;
   wire        wr_slow;
   wire        rd_fast;
   wire        rd_slow;
   wire [31:0] fast_q;
   wire [31:0] slow_q;
   reg  [31:0] fast_view;
   reg  [31:0] slow_view;
   reg  [31:0] nxt_rdata;

   // low address bits are ignored: lanes are chosen by reg_be
   assign sel_fast = (reg_addr[`PRC_ADDR_W-1:2] == FAST_OFS[`PRC_ADDR_W-1:2]);
   assign sel_slow = (reg_addr[`PRC_ADDR_W-1:2] == SLOW_OFS[`PRC_ADDR_W-1:2]);

   // an unmapped address selects nothing: writes vanish, reads give zero
   assign wr_fast  = reg_wr & sel_fast;
   assign wr_slow  = reg_wr & sel_slow;
   assign rd_fast  = reg_rd & sel_fast;
   assign rd_slow  = reg_rd & sel_slow;

   // ==========================================================
   // the two reset registers
   prc_bank
   #(
      .WIDTH   (32),
      .RST_VAL (`PRC_FAST_RST_RST),
      .WMASK   (`PRC_FAST_RST_WMASK)
   )
   u_fast
   (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .wr_en   (wr_fast),
      .wr_be   (reg_be),
      .wr_data (reg_wdata),
      .q_ff    (fast_q)
   );

   prc_bank
   #(
      .WIDTH   (32),
      .RST_VAL (`PRC_SLOW_RST_RST),
      .WMASK   (`PRC_SLOW_RST_WMASK)
   )
   u_slow
   (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .wr_en   (wr_slow),
      .wr_be   (reg_be),
      .wr_data (reg_wdata),
      .q_ff    (slow_q)
   );

   // ==========================================================
   // read views, built field by field
   // reserved positions are never assigned here, so they read zero
   // whatever write mask a bank is built with
   always @*
   begin
      fast_view                     = 32'h0000_0000;
      fast_view[`PRC_F_TIMER_TEN]   = fast_q[`PRC_F_TIMER_TEN];
      fast_view[`PRC_F_TIMER_NINE]  = fast_q[`PRC_F_TIMER_NINE];
      fast_view[`PRC_F_TIMER_EIGHT] = fast_q[`PRC_F_TIMER_EIGHT];
      fast_view[`PRC_F_USART0]      = fast_q[`PRC_F_USART0];
      fast_view[`PRC_F_ADV_TIMER1]  = fast_q[`PRC_F_ADV_TIMER1];
      fast_view[`PRC_F_SPI0]        = fast_q[`PRC_F_SPI0];
      fast_view[`PRC_F_ADV_TIMER0]  = fast_q[`PRC_F_ADV_TIMER0];
      fast_view[`PRC_F_ADC1]        = fast_q[`PRC_F_ADC1];
      fast_view[`PRC_F_ADC0]        = fast_q[`PRC_F_ADC0];
      fast_view[`PRC_F_PORT_E]      = fast_q[`PRC_F_PORT_E];
      fast_view[`PRC_F_PORT_D]      = fast_q[`PRC_F_PORT_D];
      fast_view[`PRC_F_PORT_C]      = fast_q[`PRC_F_PORT_C];
      fast_view[`PRC_F_PORT_B]      = fast_q[`PRC_F_PORT_B];
      fast_view[`PRC_F_PORT_A]      = fast_q[`PRC_F_PORT_A];
      fast_view[`PRC_F_ALT_FUNC]    = fast_q[`PRC_F_ALT_FUNC];
   end

   always @*
   begin
      slow_view                     = 32'h0000_0000;
      slow_view[`PRC_S_DAC]         = slow_q[`PRC_S_DAC];
      slow_view[`PRC_S_POWER]       = slow_q[`PRC_S_POWER];
      slow_view[`PRC_S_BACKUP]      = slow_q[`PRC_S_BACKUP];
      slow_view[`PRC_S_CAN1]        = slow_q[`PRC_S_CAN1];
      slow_view[`PRC_S_CAN0]        = slow_q[`PRC_S_CAN0];
      slow_view[`PRC_S_I2C1]        = slow_q[`PRC_S_I2C1];
      slow_view[`PRC_S_I2C0]        = slow_q[`PRC_S_I2C0];
   end

   // ==========================================================
   // read path, data valid the cycle after the strobe only
   always @*
   begin
      case ({rd_fast, rd_slow})
         2'b10:
            nxt_rdata = fast_view;
         2'b01:
            nxt_rdata = slow_view;
         default:
            nxt_rdata = 32'h0000_0000;
      endcase
   end

   always @(posedge mclk)
   begin
      if (sys_rst)
         reg_rdata_ff <= 32'h0000_0000;
      else
         reg_rdata_ff <= nxt_rdata;
   end

   // ==========================================================
   // per-peripheral reset lines, each a register bit itself so
   // release lands one cycle after the clearing write
   // general timers
   assign timer_ten_reset             = fast_q[`PRC_F_TIMER_TEN];
   assign timer_nine_reset            = fast_q[`PRC_F_TIMER_NINE];
   assign timer_eight_reset           = fast_q[`PRC_F_TIMER_EIGHT];

   // ==========================================================
   // serial, advanced timer and converter resets
   assign first_usart_reset           = fast_q[`PRC_F_USART0];
   assign second_advanced_timer_reset = fast_q[`PRC_F_ADV_TIMER1];
   assign first_spi_reset             = fast_q[`PRC_F_SPI0];
   assign first_advanced_timer_reset  = fast_q[`PRC_F_ADV_TIMER0];
   assign second_adc_reset            = fast_q[`PRC_F_ADC1];
   assign first_adc_reset             = fast_q[`PRC_F_ADC0];

   // ==========================================================
   // gpio ports and alternate-function remap
   assign port_e_reset                = fast_q[`PRC_F_PORT_E];
   assign port_d_reset                = fast_q[`PRC_F_PORT_D];
   assign port_c_reset                = fast_q[`PRC_F_PORT_C];
   assign port_b_reset                = fast_q[`PRC_F_PORT_B];
   assign port_a_reset                = fast_q[`PRC_F_PORT_A];
   assign alt_function_io_reset       = fast_q[`PRC_F_ALT_FUNC];

   // ==========================================================
   // slow bus resets
   assign dac_unit_reset              = slow_q[`PRC_S_DAC];
   assign power_control_reset         = slow_q[`PRC_S_POWER];
   assign backup_interface_reset      = slow_q[`PRC_S_BACKUP];
   assign second_can_reset            = slow_q[`PRC_S_CAN1];
   assign first_can_reset             = slow_q[`PRC_S_CAN0];
   assign second_i2c_reset            = slow_q[`PRC_S_I2C1];
   assign first_i2c_reset             = slow_q[`PRC_S_I2C0];

endmodule
